/* File: rtl/tmo_pkg.sv */
// Constants and types for the timer output mode control block
// Function
// - nonzero output mode routes compare output to pin, except PWM mode 01 when it cannot toggle
// - non-PWM channel A: off, toggle, clear, set
// - non-PWM channel B: off, toggle, clear, set
// - fast PWM A: 10 clear/set-top, 11 inverse
// - PWM A mode 01 toggles only with high bit
// - fast PWM B: 10 clear/set-top, 01 reserved
// - phase PWM A: 10 clear up, set down
// - phase PWM B: 10 clear up, 01 reserved
// - compare equal TOP: ignore match, act at TOP
// - control A bits three, two read zero
// - three-bit mode selects sequence, TOP, waveform
// - mode encodings and TOP sources as tabled
// - compare update and overflow point per mode
// - mode high bit sits at control B bit three
package tmo_pkg;

    // *****************************************************
    // Register byte offsets
    // *****************************************************
    localparam logic [7:0] ADDR_CTRL_A = 8'h00;
    localparam logic [7:0] ADDR_CTRL_B = 8'h04;
    localparam logic [7:0] ADDR_CMP_A  = 8'h08;
    localparam logic [7:0] ADDR_CMP_B  = 8'h0C;
    localparam logic [7:0] ADDR_STATUS = 8'h10;

    // *****************************************************
    // Field positions
    // *****************************************************
    localparam int MODE_A_LSB   = 6;
    localparam int MODE_B_LSB   = 4;
    localparam int WGM_LOW_LSB  = 0;
    localparam int WGM_HIGH_POS = 3;
    localparam int ST_OVF_POS   = 0;
    localparam int ST_PIN_A_POS = 1;
    localparam int ST_PIN_B_POS = 2;
    localparam int ST_SEL_A_POS = 3;
    localparam int ST_SEL_B_POS = 4;

    // *****************************************************
    // Reset values and counter limits
    // *****************************************************
    localparam logic [7:0] CTRL_A_RST   = 8'h00;
    localparam logic [7:0] CTRL_B_RST   = 8'h00;
    localparam logic [7:0] CMP_RST      = 8'h00;
    localparam logic [7:0] COUNT_MAX    = 8'hFF;
    localparam logic [7:0] COUNT_BOTTOM = 8'h00;

    // *****************************************************
    // Waveform mode codes
    // *****************************************************
    localparam logic [2:0] MODE_NORMAL  = 3'h0;
    localparam logic [2:0] MODE_PC_FULL = 3'h1;
    localparam logic [2:0] MODE_CTC     = 3'h2;
    localparam logic [2:0] MODE_FP_FULL = 3'h3;
    localparam logic [2:0] MODE_PC_CMPA = 3'h5;
    localparam logic [2:0] MODE_FP_CMPA = 3'h7;

    // Where the overflow flag is raised
    typedef enum logic [1:0] {
        TMO_OVF_NONE,
        TMO_OVF_MAX,
        TMO_OVF_BOTTOM,
        TMO_OVF_TOP
    } tmo_ovf_t;

endpackage

/* File: rtl/tmo_mode_dec.sv */
// Waveform mode decoder for the timer output mode control block
`timescale 1ns/10ps
module tmo_mode_dec (
    // Mode field
    input  wire logic [2:0]       mode_i,
    // Decoded mode
    output logic                  fast_pwm_o,
    output logic                  phase_pwm_o,
    output logic                  top_from_a_o,
    output logic                  upd_now_o,
    output tmo_pkg::tmo_ovf_t     ovf_sel_o
);

    // Mode table; reserved codes act as a plain counter with no flag
    always_comb begin
        fast_pwm_o   = 1'b0;
        phase_pwm_o  = 1'b0;
        top_from_a_o = 1'b0;
        upd_now_o    = 1'b1;
        ovf_sel_o    = tmo_pkg::TMO_OVF_NONE;
        case (mode_i)
            tmo_pkg::MODE_NORMAL: begin
                ovf_sel_o = tmo_pkg::TMO_OVF_MAX;
            end
            tmo_pkg::MODE_PC_FULL: begin
                phase_pwm_o = 1'b1;
                upd_now_o   = 1'b0;
                ovf_sel_o   = tmo_pkg::TMO_OVF_BOTTOM;
            end
            tmo_pkg::MODE_CTC: begin
                top_from_a_o = 1'b1;
                ovf_sel_o    = tmo_pkg::TMO_OVF_MAX;
            end
            tmo_pkg::MODE_FP_FULL: begin
                fast_pwm_o = 1'b1;
                upd_now_o  = 1'b0;
                ovf_sel_o  = tmo_pkg::TMO_OVF_MAX;
            end
            tmo_pkg::MODE_PC_CMPA: begin
                phase_pwm_o  = 1'b1;
                top_from_a_o = 1'b1;
                upd_now_o    = 1'b0;
                ovf_sel_o    = tmo_pkg::TMO_OVF_BOTTOM;
            end
            tmo_pkg::MODE_FP_CMPA: begin
                fast_pwm_o   = 1'b1;
                top_from_a_o = 1'b1;
                upd_now_o    = 1'b0;
                ovf_sel_o    = tmo_pkg::TMO_OVF_TOP;
            end
            default: begin
                ovf_sel_o = tmo_pkg::TMO_OVF_NONE;
            end
        endcase
    end

endmodule

/* File: rtl/tmo_chan.sv */
// One compare output channel of the timer output mode control block
`timescale 1ns/10ps
module tmo_chan #(
    parameter bit ALLOW_TOGGLE = 1'b1
) (
    // Clock and reset
    input  wire logic       clk_sys_i,
    input  wire logic       rst_n_i,
    // Timer events
    input  wire logic       tick_i,
    input  wire logic       match_i,
    input  wire logic       at_top_i,
    input  wire logic       down_i,
    input  wire logic       cmp_is_top_i,
    // Configuration
    input  wire logic [1:0] mode_i,
    input  wire logic       fast_pwm_i,
    input  wire logic       phase_pwm_i,
    input  wire logic       high_bit_i,
    // Output
    output logic            pin_o,
    output logic            connect_o
);

    logic next_pin;
    logic next_connect;

    // Event qualification
    wire pwm        = fast_pwm_i | phase_pwm_i;
    wire toggle_ok  = ALLOW_TOGGLE & high_bit_i;
    wire special    = pwm & mode_i[1] & cmp_is_top_i;
    wire eff_match  = match_i & ~special;
    wire top_action = at_top_i & (fast_pwm_i | special);

    // Pin is routed unless the code means disconnected in this mode
    assign next_connect = (mode_i != 2'b00)
                        & ~(pwm & (mode_i == 2'b01) & ~toggle_ok);

    // Next output level; only ticks carrying an event move it
    always_comb begin
        next_pin = pin_o;
        if (tick_i) begin
            if (!pwm) begin
                if (eff_match) begin
                    case (mode_i)
                        2'b01:   next_pin = ~pin_o;
                        2'b10:   next_pin = 1'b0;
                        2'b11:   next_pin = 1'b1;
                        default: next_pin = pin_o;
                    endcase
                end
            end else if (mode_i == 2'b01) begin
                if (toggle_ok && eff_match) begin
                    next_pin = ~pin_o;
                end
            end else if (mode_i[1]) begin
                if (top_action) begin
                    next_pin = ~mode_i[0];
                end else if (eff_match && fast_pwm_i) begin
                    next_pin = mode_i[0];
                end else if (eff_match) begin
                    next_pin = mode_i[0] ^ down_i;
                end
            end
        end
    end

    // Output register, zero after reset
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            pin_o     <= 1'b0;
            connect_o <= 1'b0;
        end else begin
            pin_o     <= next_pin;
            connect_o <= next_connect;
        end
    end

    // *****************************************************
    // Checks
    // *****************************************************
    a_pin_idle_hold: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        !tick_i |=> $stable(pin_o))
        else $error("output moved without a timer tick");

    a_nonpwm_clear: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        tick_i && !pwm && mode_i == 2'b10 && match_i |=> !pin_o)
        else $error("non-PWM clear on match failed");

    a_phase_up_clear: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        tick_i && phase_pwm_i && mode_i == 2'b10 && match_i && !cmp_is_top_i && !down_i
        |=> !pin_o)
        else $error("phase PWM up-count clear failed");

    a_special_top: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        tick_i && pwm && mode_i == 2'b11 && cmp_is_top_i && at_top_i |=> !pin_o)
        else $error("compare at TOP did not act at TOP");

endmodule

/* File: rtl/tmo_ctrl.sv */
// Timer output mode control with APB register access
//
// Implementation choices: the APB slave port and the register offsets.
`timescale 1ns/10ps
module tmo_ctrl #(
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input  wire logic              clk_sys_i,
    input  wire logic              rst_n_i,
    // APB slave
    input  wire logic              psel_i,
    input  wire logic              penable_i,
    input  wire logic              pwrite_i,
    input  wire logic [ADDR_W-1:0] paddr_i,
    input  wire logic [31:0]       pwdata_i,
    output logic      [31:0]       prdata_o,
    output logic                   pready_o,
    output logic                   pslverr_o,
    // Counter datapath
    input  wire logic              tick_i,
    input  wire logic [7:0]        count_i,
    input  wire logic              count_down_i,
    // Counter steering
    output logic      [7:0]        top_value_o,
    output logic                   dual_slope_o,
    output logic                   clear_at_top_o,
    output logic                   ovf_pulse_o,
    // Compare output pins
    output logic                   compare_output_pin_a_o,
    output logic                   compare_output_pin_a_sel_o,
    output logic                   compare_output_pin_b_o,
    output logic                   compare_output_pin_b_sel_o
);

    // *****************************************************
    // Register state
    // *****************************************************
    logic [1:0] output_mode_chan_a;
    logic [1:0] output_mode_chan_b;
    logic [1:0] waveform_mode_low_bits;
    logic       waveform_mode_high_bit;
    logic [7:0] compare_value_a;
    logic [7:0] compare_value_b;
    logic [7:0] cmp_a_act;
    logic [7:0] cmp_b_act;
    logic       counter_overflow_flag;

    // Decoded mode
    logic               fast_pwm;
    logic               phase_pwm;
    logic               top_from_a;
    logic               upd_now;
    tmo_pkg::tmo_ovf_t  ovf_sel;

    // *****************************************************
    // APB decode
    // *****************************************************
    wire [7:0] addr8   = paddr_i[7:0];
    wire       access  = psel_i & penable_i;
    wire       xfer    = access & pready_o;
    wire       wr_en   = xfer & pwrite_i;
    wire       hit_ca  = (addr8 == tmo_pkg::ADDR_CTRL_A);
    wire       hit_cb  = (addr8 == tmo_pkg::ADDR_CTRL_B);
    wire       hit_ma  = (addr8 == tmo_pkg::ADDR_CMP_A);
    wire       hit_mb  = (addr8 == tmo_pkg::ADDR_CMP_B);
    wire       hit_st  = (addr8 == tmo_pkg::ADDR_STATUS);
    wire       mapped  = (hit_ca | hit_cb | hit_ma | hit_mb | hit_st)
                       & (paddr_i[ADDR_W-1:0] == ADDR_W'(addr8));

    // Full waveform mode field
    wire [2:0] waveform_mode_field = {waveform_mode_high_bit, waveform_mode_low_bits};

    // Read view; reserved bits of control A stay zero
    wire [7:0] rd_ctrl_a = {output_mode_chan_a, output_mode_chan_b,
                            2'b00, waveform_mode_low_bits};
    wire [7:0] rd_ctrl_b = 8'(waveform_mode_high_bit) << tmo_pkg::WGM_HIGH_POS;
    wire [7:0] rd_status = (8'(counter_overflow_flag) << tmo_pkg::ST_OVF_POS)
                         | (8'(compare_output_pin_a_o) << tmo_pkg::ST_PIN_A_POS)
                         | (8'(compare_output_pin_b_o) << tmo_pkg::ST_PIN_B_POS)
                         | (8'(compare_output_pin_a_sel_o) << tmo_pkg::ST_SEL_A_POS)
                         | (8'(compare_output_pin_b_sel_o) << tmo_pkg::ST_SEL_B_POS);
    wire [7:0] rd_mux    = hit_ca ? rd_ctrl_a :
                           hit_cb ? rd_ctrl_b :
                           hit_ma ? compare_value_a :
                           hit_mb ? compare_value_b :
                           hit_st ? rd_status : 8'h00;

    // *****************************************************
    // Timer events
    // *****************************************************
    wire [7:0] top_value = top_from_a ? cmp_a_act : tmo_pkg::COUNT_MAX;
    wire       at_top    = (count_i == top_value);
    wire       match_a   = (count_i == cmp_a_act);
    wire       match_b   = (count_i == cmp_b_act);
    wire       top_tick  = tick_i & at_top;
    wire       ovf_event = tick_i & (
                 ((ovf_sel == tmo_pkg::TMO_OVF_MAX)    & (count_i == tmo_pkg::COUNT_MAX))
               | ((ovf_sel == tmo_pkg::TMO_OVF_BOTTOM) & (count_i == tmo_pkg::COUNT_BOTTOM))
               | ((ovf_sel == tmo_pkg::TMO_OVF_TOP)    & at_top));
    wire       ovf_clear = wr_en & hit_st & pwdata_i[tmo_pkg::ST_OVF_POS];

    // Compare buffers load at once or only at TOP
    wire       cmp_load  = upd_now | top_tick;

    // *****************************************************
    // Mode decoder and channels
    // *****************************************************
    tmo_mode_dec u_mode_dec (
        .mode_i       (waveform_mode_field),
        .fast_pwm_o   (fast_pwm),
        .phase_pwm_o  (phase_pwm),
        .top_from_a_o (top_from_a),
        .upd_now_o    (upd_now),
        .ovf_sel_o    (ovf_sel)
    );

    // Channel A may toggle in PWM modes
    tmo_chan #(.ALLOW_TOGGLE(1'b1)) u_chan_a (
        .clk_sys_i    (clk_sys_i),
        .rst_n_i      (rst_n_i),
        .tick_i       (tick_i),
        .match_i      (match_a),
        .at_top_i     (at_top),
        .down_i       (count_down_i),
        .cmp_is_top_i (cmp_a_act == top_value),
        .mode_i       (output_mode_chan_a),
        .fast_pwm_i   (fast_pwm),
        .phase_pwm_i  (phase_pwm),
        .high_bit_i   (waveform_mode_high_bit),
        .pin_o        (compare_output_pin_a_o),
        .connect_o    (compare_output_pin_a_sel_o)
    );

    // Channel B has no PWM toggle; its mode 01 is reserved there
    tmo_chan #(.ALLOW_TOGGLE(1'b0)) u_chan_b (
        .clk_sys_i    (clk_sys_i),
        .rst_n_i      (rst_n_i),
        .tick_i       (tick_i),
        .match_i      (match_b),
        .at_top_i     (at_top),
        .down_i       (count_down_i),
        .cmp_is_top_i (cmp_b_act == top_value),
        .mode_i       (output_mode_chan_b),
        .fast_pwm_i   (fast_pwm),
        .phase_pwm_i  (phase_pwm),
        .high_bit_i   (waveform_mode_high_bit),
        .pin_o        (compare_output_pin_b_o),
        .connect_o    (compare_output_pin_b_sel_o)
    );

    // *****************************************************
    // APB handshake: one wait state, answer registered
    // *****************************************************
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            pready_o  <= 1'b0;
            prdata_o  <= 32'h0000_0000;
            pslverr_o <= 1'b0;
        end else begin
            pready_o  <= access & ~pready_o;
            prdata_o  <= (access & ~pready_o & ~pwrite_i) ? {24'h00_0000, rd_mux}
                                                          : 32'h0000_0000;
            pslverr_o <= access & ~pready_o & ~mapped;
        end
    end

    // Control registers, written at the completing edge only
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            output_mode_chan_a     <= tmo_pkg::CTRL_A_RST[tmo_pkg::MODE_A_LSB +: 2];
            output_mode_chan_b     <= tmo_pkg::CTRL_A_RST[tmo_pkg::MODE_B_LSB +: 2];
            waveform_mode_low_bits <= tmo_pkg::CTRL_A_RST[tmo_pkg::WGM_LOW_LSB +: 2];
            waveform_mode_high_bit <= tmo_pkg::CTRL_B_RST[tmo_pkg::WGM_HIGH_POS];
        end else if (wr_en && hit_ca) begin
            output_mode_chan_a     <= pwdata_i[tmo_pkg::MODE_A_LSB +: 2];
            output_mode_chan_b     <= pwdata_i[tmo_pkg::MODE_B_LSB +: 2];
            waveform_mode_low_bits <= pwdata_i[tmo_pkg::WGM_LOW_LSB +: 2];
        end else if (wr_en && hit_cb) begin
            waveform_mode_high_bit <= pwdata_i[tmo_pkg::WGM_HIGH_POS];
        end
    end

    // Compare values as software sees them
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            compare_value_a <= tmo_pkg::CMP_RST;
            compare_value_b <= tmo_pkg::CMP_RST;
        end else begin
            if (wr_en && hit_ma) compare_value_a <= pwdata_i[7:0];
            if (wr_en && hit_mb) compare_value_b <= pwdata_i[7:0];
        end
    end

    // Working compare values; PWM loads at TOP to avoid glitched periods
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            cmp_a_act <= tmo_pkg::CMP_RST;
            cmp_b_act <= tmo_pkg::CMP_RST;
        end else if (cmp_load) begin
            cmp_a_act <= compare_value_a;
            cmp_b_act <= compare_value_b;
        end
    end

    // Overflow flag: a new event beats a write-one clear
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            counter_overflow_flag <= 1'b0;
        end else if (ovf_event) begin
            counter_overflow_flag <= 1'b1;
        end else if (ovf_clear) begin
            counter_overflow_flag <= 1'b0;
        end
    end

    // Steering towards the counter datapath
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            top_value_o    <= tmo_pkg::COUNT_MAX;
            dual_slope_o   <= 1'b0;
            clear_at_top_o <= 1'b0;
            ovf_pulse_o    <= 1'b0;
        end else begin
            top_value_o    <= top_value;
            dual_slope_o   <= phase_pwm;
            clear_at_top_o <= fast_pwm | top_from_a & ~phase_pwm;
            ovf_pulse_o    <= ovf_event;
        end
    end

    // *****************************************************
    // Checks
    // *****************************************************
    a_ctrl_a_reserved: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        rd_ctrl_a[3:2] == 2'b00)
        else $error("reserved control bits read nonzero");

    a_sel_follows_mode: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        !fast_pwm && !phase_pwm && output_mode_chan_a != 2'b00 ##1
        $stable(output_mode_chan_a) |-> compare_output_pin_a_sel_o)
        else $error("channel A not routed to pin");

    a_top_full_range: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        waveform_mode_field == tmo_pkg::MODE_FP_FULL |=> top_value_o == tmo_pkg::COUNT_MAX)
        else $error("fast PWM TOP is not full range");

    a_cmp_hold_pwm: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (fast_pwm || phase_pwm) && !top_tick |=> $stable(cmp_a_act) && $stable(cmp_b_act))
        else $error("compare buffer moved away from TOP");

    a_cmp_immediate: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        waveform_mode_field == tmo_pkg::MODE_NORMAL |=> cmp_a_act == $past(compare_value_a))
        else $error("compare not immediate in normal mode");

    a_ovf_bottom: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        tick_i && phase_pwm && count_i == tmo_pkg::COUNT_BOTTOM
        |=> counter_overflow_flag && ovf_pulse_o)
        else $error("overflow missing at BOTTOM");

    a_ovf_set_wins: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        ovf_event && ovf_clear |=> counter_overflow_flag)
        else $error("overflow event lost to clear");

    a_apb_one_wait: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        psel_i && penable_i && !pready_o |=> pready_o ##1 !pready_o)
        else $error("APB answer not after one wait state");

    a_chan_b_no_toggle: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        fast_pwm && output_mode_chan_b == 2'b01 && tick_i |=> $stable(compare_output_pin_b_o))
        else $error("reserved channel B mode moved the pin");

endmodule

/* File: verification/tmo_load.sv */
// External load model hanging on one compare output pin
`timescale 1ns/10ps
module tmo_load (
    // Pin side
    input  wire logic pin_i,
    input  wire logic sel_i,
    input  wire logic dir_i,
    // Level the load sees
    output logic      line_o
);
    // *********************
    // Pin level
    // *********************
    // A pin not driven out floats to the pull-up, never the last level
    assign line_o = (dir_i && sel_i) ? pin_i : 1'b1;
endmodule

/* File: verification/tb_timer8_output_mode_control.sv */
// Self-checking bench for the timer output mode control block
`timescale 1ns/10ps
module tb_timer8_output_mode_control;
    logic        clk_sys_i, rst_n_i, psel, pen, pwr, tick, down, dir_a;
    logic        pready, pslverr, err, ovf, dual, ctop, pa, sa, pb, sb, line_a, line_b;
    logic [7:0]  paddr, cnt, topv;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0]  nm [4] = '{2'b11, 2'b10, 2'b01, 2'b01};
    logic        ne [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    int          failures, comparisons, cyc;

    // *********************
    // Design and loads
    // *********************
    tmo_ctrl dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(pen),
        .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .tick_i(tick), .count_i(cnt),
        .count_down_i(down), .top_value_o(topv), .dual_slope_o(dual),
        .clear_at_top_o(ctop), .ovf_pulse_o(ovf), .compare_output_pin_a_o(pa),
        .compare_output_pin_a_sel_o(sa), .compare_output_pin_b_o(pb),
        .compare_output_pin_b_sel_o(sb));
    tmo_load la (.pin_i(pa), .sel_i(sa), .dir_i(dir_a), .line_o(line_a));
    tmo_load lb (.pin_i(pb), .sel_i(sb), .dir_i(1'b0), .line_o(line_b));

    // Clock and hang guard
    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 4000) begin
            failures++;
            test_done;
        end
    end

    // *********************
    // Tasks
    // *********************
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    // APB transfer; waits for pready with no assumed latency
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        psel   <= 1'b1;
        pwr    <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk_sys_i);
        pen <= 1'b1;
        do @(posedge clk_sys_i); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen  <= 1'b0;
    endtask
    task cfg(input logic [1:0] ma, input logic [1:0] mb, input logic h, input logic [1:0] lo);
        apb(1'b1, tmo_pkg::ADDR_CTRL_B, {28'h0, h, 3'h0});
        apb(1'b1, tmo_pkg::ADDR_CTRL_A, {24'h0, ma, mb, 2'b00, lo});
        // Steering and selects are registered one edge after the write lands
        @(posedge clk_sys_i);
        @(negedge clk_sys_i);
    endtask
    // One timer tick; outputs are looked at mid-cycle after it lands
    task tk(input logic [7:0] c, input logic d);
        @(posedge clk_sys_i);
        tick <= 1'b1;
        cnt  <= c;
        down <= d;
        @(posedge clk_sys_i);
        tick <= 1'b0;
        @(negedge clk_sys_i);
    endtask
    task pins(input logic [3:0] e);
        chk("pins", {28'h0, e}, {28'h0, pa, sa, pb, sb});
    endtask
    task tend(input string n);
        $display("test %s done", n);
    endtask
    task test_done;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // *********************
    // Main sequence
    // *********************
    initial begin
        {rst_n_i, psel, pen, pwr, tick, down, dir_a, paddr, cnt, pwdata} = '0;
        repeat (8) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        dir_a   <= 1'b1;
        apb(1'b0, tmo_pkg::ADDR_CTRL_A, 32'h0);
        chk("ctrl_a", 32'h0, rd);
        chk("top", 32'hFF, {24'h0, topv});
        apb(1'b1, tmo_pkg::ADDR_CTRL_A, 32'hFF);
        apb(1'b0, tmo_pkg::ADDR_CTRL_A, 32'h0);
        chk("ctrl_a", 32'hF3, rd);
        apb(1'b1, tmo_pkg::ADDR_CTRL_B, 32'hFF);
        apb(1'b0, tmo_pkg::ADDR_CTRL_B, 32'h0);
        chk("ctrl_b", 32'h08, rd);
        apb(1'b0, 8'h40, 32'h0);
        chk("unmapped", 32'h1, {31'h0, err});
        tend("registers");
        cfg(2'b00, 2'b00, 1'b0, 2'b00);
        apb(1'b1, tmo_pkg::ADDR_CMP_A, 32'h5);
        apb(1'b1, tmo_pkg::ADDR_CMP_B, 32'h5);
        pins(4'b0000);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, tmo_pkg::ADDR_CTRL_A, {24'h0, nm[i], nm[i], 4'h0});
            tk(8'h05, 1'b0);
            pins({ne[i], 1'b1, ne[i], 1'b1});
        end
        repeat (3) @(posedge clk_sys_i);
        pins(4'b0101);
        tk(8'hFF, 1'b0);
        chk("ovf", 32'h1, {31'h0, ovf});
        tend("non_pwm");
        cfg(2'b10, 2'b11, 1'b0, 2'b11);
        chk("slope", 32'h1, {30'h0, dual, ctop});
        tk(8'h05, 1'b0);
        pins(4'b0111);
        chk("line", 32'h1, {30'h0, line_a, line_b});
        tk(8'hFF, 1'b0);
        pins(4'b1101);
        chk("ovf", 32'h1, {31'h0, ovf});
        cfg(2'b01, 2'b01, 1'b0, 2'b11);
        chk("sel", 32'h0, {30'h0, sa, sb});
        tk(8'h05, 1'b0);
        pins(4'b1000);
        tend("fast_pwm");
        cfg(2'b10, 2'b11, 1'b0, 2'b01);
        chk("slope", 32'h2, {30'h0, dual, ctop});
        tk(8'h05, 1'b0);
        pins(4'b0111);
        tk(8'h05, 1'b1);
        pins(4'b1101);
        tk(8'h00, 1'b1);
        chk("ovf", 32'h1, {31'h0, ovf});
        tend("phase_pwm");
        cfg(2'b00, 2'b00, 1'b0, 2'b00);
        apb(1'b1, tmo_pkg::ADDR_CMP_A, 32'h9);
        apb(1'b1, tmo_pkg::ADDR_CMP_B, 32'h9);
        cfg(2'b01, 2'b01, 1'b1, 2'b01);
        chk("top", 32'h9, {24'h0, topv});
        chk("sel", 32'h2, {30'h0, sa, sb});
        tk(8'h09, 1'b0);
        chk("pin_a", 32'h0, {31'h0, pa});
        chk("ovf", 32'h0, {31'h0, ovf});
        cfg(2'b11, 2'b10, 1'b1, 2'b11);
        tk(8'h09, 1'b0);
        pins(4'b0111);
        chk("ovf", 32'h1, {31'h0, ovf});
        apb(1'b0, tmo_pkg::ADDR_STATUS, 32'h0);
        chk("status", 32'h1D, rd);
        apb(1'b1, tmo_pkg::ADDR_STATUS, 32'h1);
        apb(1'b0, tmo_pkg::ADDR_STATUS, 32'h0);
        chk("status", 32'h1C, rd);
        // Tick held at TOP while the flag is cleared: the new event must win
        tick <= 1'b1;
        apb(1'b1, tmo_pkg::ADDR_STATUS, 32'h1);
        tick <= 1'b0;
        apb(1'b0, tmo_pkg::ADDR_STATUS, 32'h0);
        chk("status", 32'h1D, rd);
        cfg(2'b00, 2'b00, 1'b0, 2'b10);
        chk("top", 32'h9, {24'h0, topv});
        chk("slope", 32'h1, {30'h0, dual, ctop});
        tend("top_source");
        test_done;
    end
endmodule
